// >>> dv/pamux_pad_model.sv
// pamux_pad_model: board circuitry on port A pins zero to three.
// assumes pull-ups on every pad; the design wins over a far-side driver.
`timescale 1ns/1ps
module pamux_pad_model (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] ext_val,
    input wire logic [3:0] ext_en,
    output logic [3:0] pad
);
    // released pad follows the far-side drive when enabled, else floats up through the pull-up, never holds old value
    always_comb begin
        pad = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | ~ext_en));
    end
endmodule : pamux_pad_model

// >>> dv/pamux_tb_top.sv
// pamux_tb_top: directed tests of the port A low pin multiplexer.
// assumes one cycle latency on every output and a pad model closing the loop.
`timescale 1ns/1ps
module pamux_tb_top;
    logic clk_sys = 1'b0; // system clock
    logic rst_n = 1'b0; // synchronous reset
    logic [15:0] cfg = pamux_pkg::PAMUX_CFG_RST; // pin nibbles
    logic [7:0] remap = 8'h00; // timer remap bits
    logic [3:0] t_oe = 4'h0; // timer output enables
    logic [7:0] spi_cfg = 8'h00; // bit 4 master
    pamux_pkg::pamux_sc_mode_t mode = pamux_pkg::PAMUX_SC_OFF;
    logic [4:0] sel_c = 5'h00; // irq pin selects
    logic [4:0] sel_d = 5'h00;
    logic [3:0] dout = 4'h0; // port data register
    pamux_pkg::pamux_periph_out_t p_out = '0;
    pamux_pkg::pamux_periph_in_t p_in;
    logic [3:0] pb_in = 4'h0; // port B alternate pins
    logic [31:0] dig = 32'h0000_0000; // other digital pins
    logic [3:0] ext_val = 4'h0; // far-side drive
    logic [3:0] ext_en = 4'h0;
    logic [1:0] usb_out = 2'h0; // usb transceiver drive, bit 0 minus
    logic [1:0] usb_oe = 2'h0;
    logic [3:0] pad, pin_out, pin_oe, data_in, pb_out, pb_oe;
    logic um_in, up_in, um_con, up_con, irq_c, irq_d;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    pamux_pad_model u_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pad(pad));

    pamux_top u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .port_a_low_config(cfg), .timer_two_remap_bits(remap),
        .timer_two_output_enables(t_oe), .serial_two_spi_config(spi_cfg), .serial_two_mode_select(mode),
        .ext_interrupt_c_pin_select(sel_c), .ext_interrupt_d_pin_select(sel_d), .port_a_data_out(dout),
        .port_a_data_in(data_in), .periph_out(p_out), .periph_in(p_in), .usb_minus_line_out(usb_out[0]),
        .usb_minus_line_oe(usb_oe[0]), .usb_plus_line_out(usb_out[1]), .usb_plus_line_oe(usb_oe[1]),
        .usb_minus_line_in(um_in),
        .usb_plus_line_in(up_in), .usb_minus_connect(um_con), .usb_plus_connect(up_con),
        .port_b_timer_in(pb_in), .port_b_timer_out(pb_out), .port_b_timer_oe(pb_oe),
        .digital_pin_levels(dig), .ext_interrupt_c(irq_c), .ext_interrupt_d(irq_d),
        .port_a_pin0_in(pad[0]), .port_a_pin1_in(pad[1]), .port_a_pin2_in(pad[2]), .port_a_pin3_in(pad[3]),
        .port_a_pin_out(pin_out), .port_a_pin_oe(pin_oe)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // three edges: sample, pad loop-back, resample
    task automatic settle(input string name);
        repeat (3) @(posedge clk_sys);
        #1;
        $display("test %s done", name);
    endtask : settle

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // hang guard, run needs well under a hundred cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle("reset");
        check("pin_oe", pin_oe, 4'h0);
        check("slave_select", p_in.serial_two_slave_select, 1'b1);
        @(posedge clk_sys);
        cfg <= 16'h9999;
        t_oe <= 4'hF;
        p_out.timer_out <= 4'h6;
        settle("timer out");
        check("pin_oe", pin_oe, 4'hF);
        check("pin_out", pin_out, 4'hA);
        @(posedge clk_sys);
        remap <= 8'hF0;
        pb_in <= 4'h5;
        ext_en <= 4'hF;
        settle("remap");
        check("pin_oe", pin_oe, 4'h0);
        check("pb_oe", pb_oe, 4'hF);
        check("pb_out", pb_out, 4'h6);
        check("timer_in", p_in.timer_in, 4'h5);
        @(posedge clk_sys);
        remap <= 8'h00;
        t_oe <= 4'h0;
        mode <= pamux_pkg::PAMUX_SC_SPI;
        spi_cfg <= 8'h10;
        p_out.serial_two_master_out <= 1'b1;
        p_out.serial_two_spi_clock <= 1'b1;
        ext_en <= 4'h2;
        ext_val <= 4'h2;
        settle("spi master");
        check("pin_oe", pin_oe, 4'h5);
        check("pin_out", pin_out, 4'h5);
        check("master_in", p_in.serial_two_master_in, 1'b1);
        @(posedge clk_sys);
        spi_cfg <= 8'h00;
        p_out.serial_two_slave_out <= 1'b1;
        ext_en <= 4'hD;
        ext_val <= 4'h5;
        settle("spi slave");
        check("pin_oe", pin_oe, 4'h2);
        check("pin_out", pin_out, 4'h2);
        check("slave_in", p_in.serial_two_slave_in, 1'b1);
        check("spi_clock_in", p_in.serial_two_spi_clock, 1'b1);
        check("slave_select", p_in.serial_two_slave_select, 1'b0);
        @(posedge clk_sys);
        mode <= pamux_pkg::PAMUX_SC_TWI;
        cfg <= 16'h4DD4;
        p_out.serial_two_twowire_data <= 1'b0;
        p_out.serial_two_twowire_clock <= 1'b1;
        // far side holds the clock low so the routed value differs from idle
        ext_en <= 4'h4;
        ext_val <= 4'h0;
        settle("two wire");
        check("pin_oe", pin_oe, 4'h2);
        check("pin_out", pin_out, 4'h0);
        check("twi_data_in", p_in.serial_two_twowire_data, 1'b0);
        check("twi_clock_in", p_in.serial_two_twowire_clock, 1'b0);
        @(posedge clk_sys);
        mode <= pamux_pkg::PAMUX_SC_UART;
        cfg <= 16'h4400;
        ext_en <= 4'h1;
        ext_val <= 4'h1;
        usb_out <= 2'h2;
        usb_oe <= 2'h2;
        settle("usb");
        check("usb_connect", {um_con, up_con}, 2'h3);
        check("usb_lines_in", {um_in, up_in}, 2'h3);
        check("usb_drive_oe", pin_oe[1:0], 2'h2);
        check("usb_drive_out", pin_out[1:0], 2'h2);
        check("data_in", data_in[1:0], 2'h0);
        // timer inputs, irq select, plain input
        @(posedge clk_sys);
        cfg <= pamux_pkg::PAMUX_CFG_RST;
        ext_en <= 4'hF;
        ext_val <= 4'hC;
        sel_c <= 5'h03;
        sel_d <= 5'h14;
        dig <= 32'h0010_0000;
        settle("inputs");
        check("timer_in", p_in.timer_in, 4'hA);
        check("data_in", data_in, 4'hC);
        check("irq", {irq_c, irq_d}, 2'h3);
        @(posedge clk_sys);
        // pins 0 and 1 open drain, pins 2 and 3 push-pull
        cfg <= 16'h1155;
        dout <= 4'h5;
        ext_en <= 4'h0;
        settle("gpio out");
        check("pin_oe", pin_oe, 4'hE);
        check("pin_out", pin_out, 4'h4);
        print_verdict();
    end
endmodule : pamux_tb_top

// >>> verilog/pamux_irq_select.sv
// pamux_irq_select: routes one selectable external interrupt from any digital pin.
// assumes pin levels are synchronous to clk_sys.
`timescale 1ns/1ps
module pamux_irq_select #(
    parameter int NPINS = 32,
    parameter int SELW = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [NPINS-1:0] pin_levels,
    input wire logic [SELW-1:0] pin_select,
    output logic irq_level
);

    // registered pick; an index past the last pin reads low
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_level <= 1'b0;
        end else if (int'(pin_select) < NPINS) begin
            irq_level <= pin_levels[pin_select];
        end else begin
            irq_level <= 1'b0;
        end
    end

endmodule : pamux_irq_select

// >>> verilog/pamux_pin_cell.sv
// pamux_pin_cell: output stage of one multiplexed pin.
// assumes the function choice for the pin is made upstream and arrives as levels.
`timescale 1ns/1ps
module pamux_pin_cell (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] cfg,
    input wire logic gpio_out,
    input wire logic alt_valid,
    input wire logic alt_data,
    input wire logic alt_od,
    input wire logic analog_ok,
    input wire logic ana_out,
    input wire logic ana_oe,
    output logic pin_out,
    output logic pin_oe,
    output logic analog_on
);

    // combinational choice of pin drive
    logic next_out; // value to register
    logic next_oe; // enable to register

    // decode the configuration nibble
    always_comb begin
        next_out = 1'b0;
        next_oe = 1'b0;
        case (cfg)
            pamux_pkg::PAMUX_CFG_OUT: begin
                next_out = gpio_out;
                next_oe = 1'b1;
            end
            pamux_pkg::PAMUX_CFG_OUT_OD: begin
                // open drain only ever pulls low
                next_oe = ~gpio_out;
            end
            pamux_pkg::PAMUX_CFG_ALT_OUT: begin
                // open-drain functions are not driven push-pull
                next_out = alt_data;
                next_oe = alt_valid & ~alt_od;
            end
            pamux_pkg::PAMUX_CFG_ALT_OD: begin
                next_oe = alt_valid & ~alt_data;
            end
            pamux_pkg::PAMUX_CFG_ANALOG: begin
                next_out = analog_ok & ana_out;
                next_oe = analog_ok & ana_oe;
            end
            default: begin
                next_oe = 1'b0;
            end
        endcase
    end

    // registered pin drive
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            analog_on <= 1'b0;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            analog_on <= analog_ok && (cfg == pamux_pkg::PAMUX_CFG_ANALOG);
        end
    end

endmodule : pamux_pin_cell

// >>> verilog/pamux_pkg.sv
// pamux_pkg: shared constants, encodings and carriers for the port A low pin multiplexer.
// assumes a single system clock with synchronous active-low reset in every user.
package pamux_pkg;

    // number of multiplexed pins and timer channels
    localparam int PAMUX_NPINS = 4;
    localparam int PAMUX_NCHAN = 4;

    // per-pin configuration nibble encodings (general port definition)
    localparam logic [3:0] PAMUX_CFG_ANALOG = 4'h0; // analog, digital buffers off
    localparam logic [3:0] PAMUX_CFG_OUT = 4'h1; // push-pull from port data
    localparam logic [3:0] PAMUX_CFG_IN = 4'h4; // plain input
    localparam logic [3:0] PAMUX_CFG_OUT_OD = 4'h5; // open-drain from port data
    localparam logic [3:0] PAMUX_CFG_ALT_OUT = 4'h9; // push-pull alternate function
    localparam logic [3:0] PAMUX_CFG_ALT_OD = 4'hD; // open-drain alternate function
    localparam logic [15:0] PAMUX_CFG_RST = 16'h4444; // all pins input after reset

    // field positions inside the configuration word, one nibble per pin
    localparam int PAMUX_CFG_PIN0_LSB = 0;
    localparam int PAMUX_CFG_PIN1_LSB = 4;
    localparam int PAMUX_CFG_PIN2_LSB = 8;
    localparam int PAMUX_CFG_PIN3_LSB = 12;

    // remap bit positions for channels one to four
    localparam int PAMUX_REMAP_CH1 = 4;
    localparam int PAMUX_REMAP_CH2 = 5;
    localparam int PAMUX_REMAP_CH3 = 6;
    localparam int PAMUX_REMAP_CH4 = 7;

    // role bit inside the serial two spi configuration, set selects master
    localparam int PAMUX_SPI_MASTER_BIT = 4;

    // idle levels presented to peripheral inputs when not routed
    localparam logic PAMUX_IDLE_DATA = 1'b0;
    localparam logic PAMUX_IDLE_HIGH = 1'b1;

    // interrupt pin select width and number of digital pins it spans
    localparam int PAMUX_IRQ_SELW = 5;
    localparam int PAMUX_IRQ_NPINS = 32;

    // serial controller two operating modes
    typedef enum logic [1:0] {
        PAMUX_SC_OFF,
        PAMUX_SC_UART,
        PAMUX_SC_SPI,
        PAMUX_SC_TWI
    } pamux_sc_mode_t;

    // signals the peripherals want to put on the pins
    typedef struct packed {
        logic [3:0] timer_out; // timer two channels four..one
        logic serial_two_master_out; // spi master data out
        logic serial_two_slave_out; // spi slave data out
        logic serial_two_spi_clock; // spi master clock out
        logic serial_two_twowire_data; // twi data, low pulls pin
        logic serial_two_twowire_clock; // twi clock, low pulls pin
    } pamux_periph_out_t;

    // signals the pins feed back into the peripherals
    typedef struct packed {
        logic [3:0] timer_in; // timer two channels four..one
        logic serial_two_slave_in; // spi slave data in
        logic serial_two_master_in; // spi master data in
        logic serial_two_spi_clock; // spi slave clock in
        logic serial_two_slave_select; // spi slave select, active low
        logic serial_two_twowire_data; // twi data in
        logic serial_two_twowire_clock; // twi clock in
    } pamux_periph_in_t;

endpackage : pamux_pkg

// >>> verilog/pamux_top.sv
// pamux_top: function multiplexer for port A pins zero to three.
// assumes synchronous pin inputs, config words from software held as plain ports.
`timescale 1ns/1ps
module pamux_top #(
    parameter bit HAS_USB = 1'b1,
    parameter int IRQ_NPINS = pamux_pkg::PAMUX_IRQ_NPINS,
    parameter int IRQ_SELW = pamux_pkg::PAMUX_IRQ_SELW
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // software configuration
    input wire logic [15:0] port_a_low_config,
    input wire logic [7:0] timer_two_remap_bits,
    input wire logic [3:0] timer_two_output_enables,
    input wire logic [7:0] serial_two_spi_config,
    input wire pamux_pkg::pamux_sc_mode_t serial_two_mode_select,
    input wire logic [IRQ_SELW-1:0] ext_interrupt_c_pin_select,
    input wire logic [IRQ_SELW-1:0] ext_interrupt_d_pin_select,
    // port data register
    input wire logic [3:0] port_a_data_out,
    output logic [3:0] port_a_data_in,
    // peripherals
    input wire pamux_pkg::pamux_periph_out_t periph_out,
    output pamux_pkg::pamux_periph_in_t periph_in,
    // usb transceiver
    input wire logic usb_minus_line_out,
    input wire logic usb_minus_line_oe,
    input wire logic usb_plus_line_out,
    input wire logic usb_plus_line_oe,
    output logic usb_minus_line_in,
    output logic usb_plus_line_in,
    output logic usb_minus_connect,
    output logic usb_plus_connect,
    // alternate timer pins on port B
    input wire logic [3:0] port_b_timer_in,
    output logic [3:0] port_b_timer_out,
    output logic [3:0] port_b_timer_oe,
    // other digital pins seen by the interrupt selectors
    input wire logic [IRQ_NPINS-1:0] digital_pin_levels,
    output logic ext_interrupt_c,
    output logic ext_interrupt_d,
    // pads
    input wire logic port_a_pin0_in,
    input wire logic port_a_pin1_in,
    input wire logic port_a_pin2_in,
    input wire logic port_a_pin3_in,
    output logic [3:0] port_a_pin_out,
    output logic [3:0] port_a_pin_oe
);

    // pad inputs gathered
    logic [3:0] pin_in;
    assign pin_in = {port_a_pin3_in, port_a_pin2_in, port_a_pin1_in, port_a_pin0_in};

    // configuration nibbles, one per pin
    logic [3:0] cfg [4];
    assign cfg[0] = port_a_low_config[pamux_pkg::PAMUX_CFG_PIN0_LSB +: 4];
    assign cfg[1] = port_a_low_config[pamux_pkg::PAMUX_CFG_PIN1_LSB +: 4];
    assign cfg[2] = port_a_low_config[pamux_pkg::PAMUX_CFG_PIN2_LSB +: 4];
    assign cfg[3] = port_a_low_config[pamux_pkg::PAMUX_CFG_PIN3_LSB +: 4];

    // remap bit per channel, index 0 is channel one
    logic [3:0] remap;
    assign remap = {timer_two_remap_bits[pamux_pkg::PAMUX_REMAP_CH4],
                    timer_two_remap_bits[pamux_pkg::PAMUX_REMAP_CH3],
                    timer_two_remap_bits[pamux_pkg::PAMUX_REMAP_CH2],
                    timer_two_remap_bits[pamux_pkg::PAMUX_REMAP_CH1]};

    // timer owns its port A pin only when enabled and not remapped
    logic [3:0] tim_on_a;
    assign tim_on_a = ~remap & timer_two_output_enables;

    // serial controller role decode
    logic sc_spi; // spi mode
    logic sc_twi; // two-wire mode
    logic sc_master; // spi master role
    assign sc_spi = (serial_two_mode_select == pamux_pkg::PAMUX_SC_SPI);
    assign sc_twi = (serial_two_mode_select == pamux_pkg::PAMUX_SC_TWI);
    assign sc_master = serial_two_spi_config[pamux_pkg::PAMUX_SPI_MASTER_BIT];

    // alternate function offered to each pin
    logic [3:0] alt_valid;
    logic [3:0] alt_data;
    logic [3:0] alt_od;

    // function priority: timer first, then serial controller
    always_comb begin
        alt_valid = 4'h0;
        alt_data = 4'h0;
        alt_od = 4'h0;
        if (tim_on_a[0]) begin
            alt_valid[0] = 1'b1;
            alt_data[0] = periph_out.timer_out[0];
        end else if (sc_spi && sc_master) begin
            alt_valid[0] = 1'b1;
            alt_data[0] = periph_out.serial_two_master_out;
        end
        if (tim_on_a[2]) begin
            alt_valid[1] = 1'b1;
            alt_data[1] = periph_out.timer_out[2];
        end else if (sc_twi) begin
            alt_valid[1] = 1'b1;
            alt_data[1] = periph_out.serial_two_twowire_data;
            alt_od[1] = 1'b1;
        end else if (sc_spi && !sc_master) begin
            alt_valid[1] = 1'b1;
            alt_data[1] = periph_out.serial_two_slave_out;
        end
        if (tim_on_a[3]) begin
            alt_valid[2] = 1'b1;
            alt_data[2] = periph_out.timer_out[3];
        end else if (sc_twi) begin
            alt_valid[2] = 1'b1;
            alt_data[2] = periph_out.serial_two_twowire_clock;
            alt_od[2] = 1'b1;
        end else if (sc_spi && sc_master) begin
            alt_valid[2] = 1'b1;
            alt_data[2] = periph_out.serial_two_spi_clock;
        end
        if (tim_on_a[1]) begin
            alt_valid[3] = 1'b1;
            alt_data[3] = periph_out.timer_out[1];
        end
    end

    // analog side signals; only pins 0 and 1 carry usb
    logic [3:0] ana_ok;
    logic [3:0] ana_out;
    logic [3:0] ana_oe;
    logic [3:0] ana_on;
    assign ana_ok = {2'b00, HAS_USB, HAS_USB};
    assign ana_out = {2'b00, usb_plus_line_out, usb_minus_line_out};
    assign ana_oe = {2'b00, usb_plus_line_oe, usb_minus_line_oe};

    // pin drive from port data, alternate or analog path
    // one cell per pin; port data drives the pin only under the two port output nibbles
    for (genvar p = 0; p < pamux_pkg::PAMUX_NPINS; p++) begin : g_pin
        pamux_pin_cell u_cell (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .cfg(cfg[p]),
            .gpio_out(port_a_data_out[p]),
            .alt_valid(alt_valid[p]),
            .alt_data(alt_data[p]),
            .alt_od(alt_od[p]),
            .analog_ok(ana_ok[p]),
            .ana_out(ana_out[p]),
            .ana_oe(ana_oe[p]),
            .pin_out(port_a_pin_out[p]),
            .pin_oe(port_a_pin_oe[p]),
            .analog_on(ana_on[p])
        );
    end

    assign usb_minus_connect = ana_on[0];
    assign usb_plus_connect = ana_on[1];

    // port input sampling
    // analog pins read low since the digital buffer is off
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_a_data_in <= 4'h0;
            usb_minus_line_in <= 1'b0;
            usb_plus_line_in <= 1'b0;
        end else begin
            for (int p = 0; p < pamux_pkg::PAMUX_NPINS; p++) begin
                port_a_data_in[p] <= (cfg[p] == pamux_pkg::PAMUX_CFG_ANALOG) ? 1'b0 : pin_in[p];
            end
            usb_minus_line_in <= HAS_USB & pin_in[0];
            usb_plus_line_in <= HAS_USB & pin_in[1];
        end
    end

    // timer channel inputs in channel order
    logic [3:0] tim_pin_a;
    assign tim_pin_a = {pin_in[2], pin_in[1], pin_in[3], pin_in[0]};

    // peripheral input routing, registered
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            periph_in.timer_in <= 4'h0;
            periph_in.serial_two_slave_in <= pamux_pkg::PAMUX_IDLE_DATA;
            periph_in.serial_two_master_in <= pamux_pkg::PAMUX_IDLE_DATA;
            periph_in.serial_two_spi_clock <= pamux_pkg::PAMUX_IDLE_DATA;
            periph_in.serial_two_slave_select <= pamux_pkg::PAMUX_IDLE_HIGH;
            periph_in.serial_two_twowire_data <= pamux_pkg::PAMUX_IDLE_HIGH;
            periph_in.serial_two_twowire_clock <= pamux_pkg::PAMUX_IDLE_HIGH;
        end else begin
            periph_in.timer_in <= (remap & port_b_timer_in) | (~remap & tim_pin_a);
            periph_in.serial_two_slave_in <= (sc_spi && !sc_master) ? pin_in[0] : pamux_pkg::PAMUX_IDLE_DATA;
            periph_in.serial_two_master_in <= (sc_spi && sc_master) ? pin_in[1] : pamux_pkg::PAMUX_IDLE_DATA;
            periph_in.serial_two_spi_clock <= (sc_spi && !sc_master) ? pin_in[2] : pamux_pkg::PAMUX_IDLE_DATA;
            periph_in.serial_two_slave_select <= (sc_spi && !sc_master) ? pin_in[3]
                                                                          : pamux_pkg::PAMUX_IDLE_HIGH;
            periph_in.serial_two_twowire_data <= sc_twi ? pin_in[1] : pamux_pkg::PAMUX_IDLE_HIGH;
            periph_in.serial_two_twowire_clock <= sc_twi ? pin_in[2] : pamux_pkg::PAMUX_IDLE_HIGH;
        end
    end

    // port B timer outputs for remapped, enabled channels
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port_b_timer_out <= 4'h0;
            port_b_timer_oe <= 4'h0;
        end else begin
            port_b_timer_out <= remap & periph_out.timer_out;
            port_b_timer_oe <= remap & timer_two_output_enables;
        end
    end

    // full digital pin set for interrupt selection; low four are this block's
    logic [IRQ_NPINS-1:0] irq_levels;
    assign irq_levels = {digital_pin_levels[IRQ_NPINS-1:4], pin_in};

    pamux_irq_select #(.NPINS(IRQ_NPINS), .SELW(IRQ_SELW)) u_irq_c (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_levels(irq_levels),
        .pin_select(ext_interrupt_c_pin_select),
        .irq_level(ext_interrupt_c)
    );

    pamux_irq_select #(.NPINS(IRQ_NPINS), .SELW(IRQ_SELW)) u_irq_d (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_levels(irq_levels),
        .pin_select(ext_interrupt_d_pin_select),
        .irq_level(ext_interrupt_d)
    );

    // checks on the registered pin behaviour
    property p_tim1_pin0;
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && tim_on_a[0] && cfg[0] == pamux_pkg::PAMUX_CFG_ALT_OUT)
            |=> (port_a_pin_oe[0] && port_a_pin_out[0] == $past(periph_out.timer_out[0]));
    endproperty
    a_tim1_pin0: assert property (p_tim1_pin0) else $error("pin0 not carrying timer ch1");

    property p_mosi_pin0;
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && !tim_on_a[0] && sc_spi && sc_master && cfg[0] == pamux_pkg::PAMUX_CFG_ALT_OUT)
            |=> (port_a_pin_out[0] == $past(periph_out.serial_two_master_out));
    endproperty
    a_mosi_pin0: assert property (p_mosi_pin0) else $error("pin0 not carrying spi master out");

    property p_slave_in;
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && sc_spi && !sc_master) ##1 (sc_spi && !sc_master)
            |-> periph_in.serial_two_slave_in == $past(port_a_pin0_in);
    endproperty
    a_slave_in: assert property (p_slave_in) else $error("spi slave data in not from pin0");

    property p_usb_minus;
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && cfg[0] == pamux_pkg::PAMUX_CFG_ANALOG) |=> (usb_minus_connect == HAS_USB);
    endproperty
    a_usb_minus: assert property (p_usb_minus) else $error("usb minus not connected");

    property p_sda_od;
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && !tim_on_a[2] && sc_twi && cfg[1] == pamux_pkg::PAMUX_CFG_ALT_OD)
            |=> (port_a_pin_oe[1] == !$past(periph_out.serial_two_twowire_data)) && !port_a_pin_out[1];
    endproperty
    a_sda_od: assert property (p_sda_od) else $error("pin1 twi data not open drain");

    property p_sclk_pin2;
        @(posedge clk_sys) disable iff (!rst_n)
        (rst_n && !tim_on_a[3] && sc_spi && sc_master && cfg[2] == pamux_pkg::PAMUX_CFG_ALT_OUT)
            |=> (port_a_pin_oe[2] && port_a_pin_out[2] == $past(periph_out.serial_two_spi_clock));
    endproperty
    a_sclk_pin2: assert property (p_sclk_pin2) else $error("pin2 not carrying spi clock");

    property p_tim_in; // sampled rst_n skips the release edge where flops still reset
        @(posedge clk_sys) disable iff (!rst_n)
        rst_n && !remap[1] |=> periph_in.timer_in[1] == $past(port_a_pin3_in);
    endproperty
    a_tim_in: assert property (p_tim_in) else $error("timer ch2 input not from pin3");

    property p_remap_out;
        @(posedge clk_sys) disable iff (!rst_n)
        rst_n && remap[0] |=> (port_b_timer_oe[0] == $past(timer_two_output_enables[0])) && !port_a_pin_oe[0]
            || $past(cfg[0]) != pamux_pkg::PAMUX_CFG_ALT_OUT || $past(sc_spi && sc_master);
    endproperty
    a_remap_out: assert property (p_remap_out) else $error("remapped channel still on port A");

    property p_gpio;
        @(posedge clk_sys) disable iff (!rst_n)
        (cfg[3] == pamux_pkg::PAMUX_CFG_OUT) |=> (port_a_pin_oe[3] && port_a_pin_out[3] == $past(port_a_data_out[3]));
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin3 not following port data");

    c_twi: cover property (@(posedge clk_sys) disable iff (!rst_n) sc_twi && !port_a_pin_oe[1] ##1 port_a_pin_oe[1]);
    c_usb: cover property (@(posedge clk_sys) disable iff (!rst_n) usb_minus_connect && usb_plus_connect);
    c_remap: cover property (@(posedge clk_sys) disable iff (!rst_n) port_b_timer_oe[2]);

endmodule : pamux_top
